// ---- src/host_dma_setup_control.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "host_dma_defines.svh"


module host_dma_setup_control
    import host_dma_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Processor command port
    input  wire logic                     cmdValid,
    input  wire logic [7:0]               cmdCode,
    input  wire logic [15:0]              cmdData,
    output logic      [15:0]              rdData,
    output logic                          rdValid,
    // Byte count register contents
    input  wire logic [`BYTE_COUNT_W-1:0] byteCount,
    // System DMA controller side
    input  wire logic                     dmaAck,
    input  wire logic                     endOfTransferIn,
    output logic                          hostRequestOut,
    // Buffer routing
    output logic                          bufferRegionSel,
    output logic                          transferDirection,
    // Completion events
    output logic                          transferDoneFlag,
    output logic                          bufferStateUpdate
);
    // Registered state, its next value and decode terms
    dma_ctrl_s cur_reg;
    dma_ctrl_s cur_next;
    logic      burstDone;
    logic      ackNow;
    logic      endHit;
    logic      wrSetup;
    logic      rdSetup;
    dma_cfg_s  wrCfg;

    // Word cycles per request; reserved code falls back to single
    function automatic logic [3:0] burstLimit(input logic [1:0] sel);
        case (sel)
            `BURST_CODE_SINGLE: burstLimit = `BURST_LEN_SINGLE;
            `BURST_CODE_FOUR:   burstLimit = `BURST_LEN_FOUR;
            `BURST_CODE_EIGHT:  burstLimit = `BURST_LEN_EIGHT;
            default:            burstLimit = `BURST_LEN_SINGLE;
        endcase
    endfunction : burstLimit

    // Reserved bits are never stored, so they read as zero
    function automatic logic [15:0] packCfg(input dma_cfg_s c);
        packCfg = `SETUP_RESET;
        packCfg[`BURST_SEL_MSB:`BURST_SEL_LSB] = c.burstSel;
        packCfg[`GO_BIT]         = c.go;
        packCfg[`COUNT_MODE_BIT] = c.countMode;
        packCfg[`REGION_BIT]     = c.region;
        packCfg[`DIRECTION_BIT]  = c.direction;
    endfunction : packCfg

    burst_counter u_burst (
        .clk       (clk),
        .rst_n     (rst_n),
        .clear     (cur_reg.state != ST_REQ),
        .ackIn     (ackNow),
        .limit     (burstLimit(cur_reg.cfg.burstSel)),
        .burstDone (burstDone)
    );

    // Command decode and write field extraction
    assign wrSetup          = cmdValid && (cmdCode == `DMA_SETUP_WR_CODE);
    assign rdSetup          = cmdValid && (cmdCode == `DMA_SETUP_RD_CODE);
    assign wrCfg.burstSel   = cmdData[`BURST_SEL_MSB:`BURST_SEL_LSB];
    assign wrCfg.go         = cmdData[`GO_BIT];
    assign wrCfg.countMode  = cmdData[`COUNT_MODE_BIT];
    assign wrCfg.region     = cmdData[`REGION_BIT];
    assign wrCfg.direction  = cmdData[`DIRECTION_BIT];

    // Transfer ends on last counted word, or on the external end input when not counting
    assign ackNow = (cur_reg.state == ST_REQ) && dmaAck;
    assign endHit = (ackNow && cur_reg.cfg.countMode
                        && (cur_reg.remaining <= `BYTES_PER_WORD))
                 || (!cur_reg.cfg.countMode && endOfTransferIn
                        && (cur_reg.state != ST_IDLE));

    // Next state of the whole control block
    always_comb begin
        cur_next          = cur_reg;
        cur_next.doneFlag = 1'b0;
        cur_next.rdValid  = 1'b0;
        case (cur_reg.state)
            ST_IDLE: begin
                if (cur_reg.cfg.go && (!cur_reg.cfg.countMode
                        || (cur_reg.remaining != `BYTE_COUNT_ZERO))) begin
                    cur_next.state = ST_REQ;
                end
            end
            ST_REQ: begin
                if (burstDone) begin
                    cur_next.state = ST_GAP;
                end
            end
            // One idle cycle lets the controller see the request drop
            ST_GAP: begin
                cur_next.state = ST_REQ;
            end
            default: begin
                cur_next.state = ST_IDLE;
            end
        endcase
        // Odd final byte still needs one word cycle, so saturate at zero
        if (ackNow && cur_reg.cfg.countMode) begin
            cur_next.remaining = (cur_reg.remaining > `BYTES_PER_WORD)
                               ? cur_reg.remaining - `BYTES_PER_WORD
                               : `BYTE_COUNT_ZERO;
        end
        if (endHit) begin
            cur_next.cfg.go   = 1'b0;
            cur_next.state    = ST_IDLE;
            cur_next.doneFlag = 1'b1;
        end
        if (!cur_reg.cfg.go) begin
            cur_next.state = ST_IDLE;
        end
        // A software write overrides the self-clear in the same cycle
        if (wrSetup) begin
            cur_next.cfg = wrCfg;
            if (!wrCfg.go) begin
                cur_next.state = ST_IDLE;
            end else if (!cur_reg.cfg.go && wrCfg.countMode) begin
                cur_next.remaining = byteCount;
            end
        end
        if (rdSetup) begin
            cur_next.rdData  = packCfg(cur_reg.cfg);
            cur_next.rdValid = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // Outputs
    assign hostRequestOut    = (cur_reg.state == ST_REQ) && cur_reg.cfg.go;
    assign bufferRegionSel   = cur_reg.cfg.region;
    assign transferDirection = cur_reg.cfg.direction;
    assign transferDoneFlag  = cur_reg.doneFlag;
    assign bufferStateUpdate = cur_reg.doneFlag;
    assign rdData            = cur_reg.rdData;
    assign rdValid           = cur_reg.rdValid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    burst_end_a: assert property (ackNow && burstDone && !endHit && !wrSetup
            |=> !hostRequestOut ##1 (hostRequestOut || !cur_reg.cfg.go))
        else $error("request not dropped for one cycle after burst");
    burst_map_a: assert property (ackNow
            && (cur_reg.cfg.burstSel == `BURST_CODE_SINGLE) |-> burstDone)
        else $error("single-cycle burst did not end after one ack");
    abort_stop_a: assert property (wrSetup && !wrCfg.go |=> !hostRequestOut [*2])
        else $error("request seen after transfer was aborted");
    self_clear_a: assert property (endHit && !wrSetup |=> !cur_reg.cfg.go && transferDoneFlag)
        else $error("go bit not cleared on completion");
    ext_end_a: assert property (!cur_reg.cfg.countMode && endOfTransferIn
            && hostRequestOut && !wrSetup |=> transferDoneFlag && !hostRequestOut)
        else $error("external end input did not end transfer");
    count_load_a: assert property (wrSetup && wrCfg.go && wrCfg.countMode
            && !cur_reg.cfg.go |=> cur_reg.remaining == $past(byteCount))
        else $error("byte counter not loaded at start");
    nonzero_req_a: assert property (hostRequestOut && cur_reg.cfg.countMode
            |-> cur_reg.remaining != `BYTE_COUNT_ZERO)
        else $error("request raised with zero byte count");
    count_done_a: assert property (cur_reg.cfg.countMode && ackNow
            && (cur_reg.remaining == `BYTES_PER_WORD) |=> transferDoneFlag && bufferStateUpdate)
        else $error("count reached without done flag");
    route_a: assert property (wrSetup
            |=> bufferRegionSel == $past(cmdData[`REGION_BIT])
            && transferDirection == $past(cmdData[`DIRECTION_BIT]))
        else $error("routing outputs do not follow setup write");
    reserved_zero_a: assert property (rdSetup
            |=> (rdData & ~`SETUP_USED_MASK) == `SETUP_RESET)
        else $error("reserved setup bits read non-zero");

    // Request, completion, read strobe and routing timing
    zero_count_a: assert property (cur_reg.state == ST_IDLE && cur_reg.cfg.go
            && cur_reg.cfg.countMode && (cur_reg.remaining == `BYTE_COUNT_ZERO)
            && !wrSetup |=> !hostRequestOut)
        else $error("request raised without a byte count");
    req_hold_a: assert property (hostRequestOut && !burstDone && !endHit && !wrSetup
            |=> hostRequestOut)
        else $error("request dropped inside a burst");
    done_pulse_a: assert property (transferDoneFlag |=> !transferDoneFlag)
        else $error("done flag held longer than one cycle");
    read_pulse_a: assert property (rdValid == $past(rdSetup))
        else $error("read data strobe out of step with read command");
    route_hold_a: assert property (!wrSetup
            |=> $stable(bufferRegionSel) && $stable(transferDirection))
        else $error("routing outputs changed without a setup write");

    // Main scenarios the bench should reach
    burst8_c: cover property (cur_reg.cfg.burstSel == `BURST_CODE_EIGHT && ackNow [*8]);
    count_end_c: cover property (cur_reg.cfg.countMode && transferDoneFlag);
    ext_end_c: cover property (!cur_reg.cfg.countMode && transferDoneFlag);
    abort_c: cover property (hostRequestOut && wrSetup && !wrCfg.go);
    gap_c: cover property (hostRequestOut ##1 !hostRequestOut ##1 hostRequestOut);
endmodule : host_dma_setup_control

`default_nettype wire

// ---- src/host_dma_defines.svh ----
`ifndef HOST_DMA_DEFINES_SVH
`define HOST_DMA_DEFINES_SVH

// Command codes of the setup register on the processor port
`define DMA_SETUP_RD_CODE   8'h21
`define DMA_SETUP_WR_CODE   8'hA1

// Field positions inside the setup word
`define BURST_SEL_MSB       6
`define BURST_SEL_LSB       5
`define GO_BIT              4
`define COUNT_MODE_BIT      2
`define REGION_BIT          1
`define DIRECTION_BIT       0
`define SETUP_RESET         16'h0000
`define SETUP_USED_MASK     16'h0077

// Burst length codes and word cycles per burst
`define BURST_CODE_SINGLE   2'h0
`define BURST_CODE_FOUR     2'h1
`define BURST_CODE_EIGHT    2'h2
`define BURST_LEN_SINGLE    4'h1
`define BURST_LEN_FOUR      4'h4
`define BURST_LEN_EIGHT     4'h8

// Byte counting on the 16-bit data bus
`define BYTE_COUNT_W        16
`define BYTES_PER_WORD      16'h0002
`define BYTE_COUNT_ZERO     16'h0000
`define BURST_COUNT_ZERO    4'h0
`define BURST_COUNT_ONE     4'h1

`endif

// ---- src/host_dma_pkg.sv ----
`default_nettype none

package host_dma_pkg;
    `include "host_dma_defines.svh"

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_GAP
    } dma_state_e;

    // Software-visible setup fields
    typedef struct packed {
        logic [1:0] burstSel;
        logic       go;
        logic       countMode;
        logic       region;
        logic       direction;
    } dma_cfg_s;

    // Whole state of the control block
    typedef struct packed {
        dma_cfg_s                  cfg;
        dma_state_e                state;
        logic [`BYTE_COUNT_W-1:0]  remaining;
        logic [15:0]               rdData;
        logic                      rdValid;
        logic                      doneFlag;
    } dma_ctrl_s;

    // Whole state of the burst counter
    typedef struct packed {
        logic [3:0] count;
    } burst_state_s;
endpackage : host_dma_pkg

`default_nettype wire

// ---- src/burst_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "host_dma_defines.svh"

module burst_counter
    import host_dma_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Burst control
    input  wire logic       clear,
    input  wire logic       ackIn,
    input  wire logic [3:0] limit,
    output logic            burstDone
);
    burst_state_s cur_reg;
    burst_state_s cur_next;

    // Last acknowledged word cycle of the burst
    assign burstDone = ackIn && ((cur_reg.count + `BURST_COUNT_ONE) >= limit);

    // Count acknowledged cycles, restart on every burst
    always_comb begin
        cur_next = cur_reg;
        if (clear || burstDone) begin
            cur_next.count = `BURST_COUNT_ZERO;
        end else if (ackIn) begin
            cur_next.count = cur_reg.count + `BURST_COUNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    burst_bound_a: assert property (cur_reg.count < `BURST_LEN_EIGHT)
        else $error("burst counter ran past eight cycles");
endmodule : burst_counter

`default_nettype wire

// ---- verif/dma_partner.sv ----
`timescale 1ns/100ps
`default_nettype none

module dma_partner (
    // Clock
    input  wire logic clk,
    // Control from the bench
    input  wire logic slow,
    input  wire logic endNow,
    // Link to the block
    input  wire logic hostRequestOut,
    output logic      dmaAck,
    output logic      endOfTransferIn
);
    logic phase;

    initial begin
        phase = 1'b1;
        endOfTransferIn = 1'b0;
    end

    // Slow mode skips every other cycle so bursts stretch out
    always @(posedge clk) begin
        phase <= #1 slow ? ~phase : 1'b1;
        endOfTransferIn <= #1 endNow;
    end

    // Acknowledge only while a request stands
    assign dmaAck = hostRequestOut & phase;
endmodule : dma_partner

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "host_dma_defines.svh"

module testbench;
    logic        clk, rst_n, cmdValid, slow, endNow, prevReq;
    logic [7:0]  cmdCode;
    logic [15:0] cmdData, rdData, byteCount;
    logic        rdValid, dmaAck, endOfTransferIn, hostRequestOut;
    logic        bufferRegionSel, transferDirection, transferDoneFlag, bufferStateUpdate;
    int          n_errors, cmp_count, cycles, acks, bursts, dones, runLen, maxRun;

    host_dma_setup_control uut (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdData(cmdData), .rdData(rdData), .rdValid(rdValid),
        .byteCount(byteCount), .dmaAck(dmaAck), .endOfTransferIn(endOfTransferIn),
        .hostRequestOut(hostRequestOut), .bufferRegionSel(bufferRegionSel),
        .transferDirection(transferDirection), .transferDoneFlag(transferDoneFlag),
        .bufferStateUpdate(bufferStateUpdate));

    dma_partner partner (.clk(clk), .slow(slow), .endNow(endNow),
        .hostRequestOut(hostRequestOut), .dmaAck(dmaAck), .endOfTransferIn(endOfTransferIn));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Link monitor, sees pre-edge values
    always @(posedge clk) begin
        if (hostRequestOut === 1'b1 && dmaAck === 1'b1) begin
            acks++;
            runLen++;
        end
        if (hostRequestOut !== 1'b1) runLen = 0;
        if (runLen > maxRun) maxRun = runLen;
        if (hostRequestOut === 1'b1 && prevReq !== 1'b1) bursts++;
        prevReq = hostRequestOut;
        if (transferDoneFlag === 1'b1) dones++;
        if (transferDoneFlag !== bufferStateUpdate) check_word(16'h0001, 16'h0000);
    end

    // Hang guard, far above the hundred-odd cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            give_verdict();
        end
    end

    task check_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : check_word

    task check_count(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            n_errors++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask : check_count

    // One-cycle command strobe, entered just after an edge
    task cmd(input logic [7:0] code, input logic [15:0] data);
        cmdCode = code;
        cmdData = data;
        cmdValid = 1'b1;
        @(posedge clk);
        #1 cmdValid = 1'b0;
    endtask : cmd

    task rd_check(input logic [15:0] exp);
        cmd(`DMA_SETUP_RD_CODE, 16'h0000);
        check_word({15'h0000, rdValid}, 16'h0001);
        check_word(rdData, exp);
        // Idle edge so a following command does not retoggle the strobe
        @(posedge clk) #1;
    endtask : rd_check

    task clear_counts;
        acks = 0;
        bursts = 0;
        dones = 0;
        maxRun = 0;
    endtask : clear_counts

    task wait_done;
        for (int i = 0; i < 400 && transferDoneFlag !== 1'b1; i++) @(posedge clk) #1;
        @(posedge clk) #1;
    endtask : wait_done

    task test_fields;
        rd_check(16'h0000);
        byteCount = 16'h0000;
        clear_counts();
        cmd(`DMA_SETUP_WR_CODE, 16'hFFFF);
        check_word({14'h0000, bufferRegionSel, transferDirection}, 16'h0003);
        repeat (20) @(posedge clk) #1;
        check_count(bursts, 0);
        rd_check(16'h0077);
        cmd(`DMA_SETUP_WR_CODE, 16'h0000);
        check_word({14'h0000, bufferRegionSel, transferDirection}, 16'h0000);
        @(posedge clk) #1;
        $display("fields done");
    endtask : test_fields

    task test_bursts;
        int len;
        for (int c = 0; c < 3; c++) begin
            len = (c == 0) ? 1 : c * 4;
            byteCount = 16'(len * 4);
            clear_counts();
            cmd(`DMA_SETUP_WR_CODE, 16'(c * 32 + 20 + c % 2));
            check_word({15'h0000, transferDirection}, 16'(c % 2));
            wait_done();
            check_count(acks, len * 2);
            check_count(maxRun, len);
            check_count(bursts, 2);
            check_count(dones, 1);
            rd_check(16'(c * 32 + 4 + c % 2));
        end
        $display("bursts done");
    endtask : test_bursts

    task test_slow_odd;
        slow = 1'b1;
        byteCount = 16'h0005;
        clear_counts();
        cmd(`DMA_SETUP_WR_CODE, 16'h0014);
        wait_done();
        check_count(acks, 3);
        check_count(bursts, 3);
        slow = 1'b0;
        $display("slow odd done");
    endtask : test_slow_odd

    task test_external;
        byteCount = 16'h0002;
        clear_counts();
        cmd(`DMA_SETUP_WR_CODE, 16'h0030);
        repeat (12) @(posedge clk) #1;
        endNow = 1'b1;
        wait_done();
        endNow = 1'b0;
        check_count(dones, 1);
        check_count(maxRun, 4);
        rd_check(16'h0020);
        clear_counts();
        cmd(`DMA_SETUP_WR_CODE, 16'h0010);
        repeat (5) @(posedge clk) #1;
        cmd(`DMA_SETUP_WR_CODE, 16'h0000);
        @(posedge clk) #1;
        check_word({15'h0000, hostRequestOut}, 16'h0000);
        bursts = 0;
        repeat (10) @(posedge clk) #1;
        check_count(bursts + dones, 0);
        $display("external done");
    endtask : test_external

    task give_verdict;
        $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // Main sequence
    initial begin
        rst_n = 1'b0;
        cmdValid = 1'b0;
        cmdCode = 8'h00;
        cmdData = 16'h0000;
        byteCount = 16'h0000;
        slow = 1'b0;
        endNow = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        test_fields();
        test_bursts();
        test_slow_odd();
        test_external();
        give_verdict();
    end
endmodule : testbench

`default_nettype wire
